// file: rtl/ir_burst_pkg.sv
// Summary of operation
// (RQ1) Burst generator idles until the burst enable control bit is written one.
// (RQ2) A read-only control bit mirrors the carrier-sense input level.
// (RQ3) 8-bit prescaler on the baud strobe makes the tick for period and on-time.
// (RQ4) Test bit speeds up the counters; software keeps it clear in normal use.
// (RQ5) Polarity bit set makes the LED drive active low, else active high.
// (RQ6) Receiver power control bit drives the receiver power pin directly.
// (RQ7) Carrier-sense enable bit starts the periodic sequencer; zero keeps it idle.
// (RQ8) Period lasts (cycle field + 1) baud ticks via an 8-bit down-counter.
// (RQ9) Active pulse lasts high-span field baud ticks via an 8-bit down-counter.
// (RQ10) Receiver power stays high for (listen field + 1) slow ticks.
// (RQ11) Idle counter steps only at listen terminal count, repeating the power-up.
// (RQ12) Holding word gives two bytes; low seven bits load the period-count counter.
// (RQ13) Byte top bit set emits pulses; clear holds the output inactive.
// (RQ14) Software writes the first word before setting the burst enable bit.
// (RQ15) Upper byte is consumed first, then the lower byte.
// (RQ16) Loading the upper byte parks the lower byte and pulses holding-empty.
// (RQ17) Carrier input is sampled as power drops; high pulses carrier-present.
// (RQ18) On-time counter freezes at zero so output stays inactive to period end.
// (RQ19) Carrier-sense input passes a two flip-flop synchroniser before any use.
// (RQ20) With burst enable low the LED is inactive and burst counters reset.
package ir_burst_pkg;
  localparam logic [11:0] MAIN_CONTROL_OFS = 12'h0A0;
  localparam logic [11:0] TIMING_CONFIG_OFS = 12'h0A4;
  localparam logic [11:0] BURST_HOLDING_OFS = 12'h0A8;
  // Main control fields.
  localparam int BURST_EN_BIT = 0;
  localparam int SENSE_EN_BIT = 1;
  localparam int RX_PWR_BIT = 2;
  localparam int POL_FLIP_BIT = 3;
  localparam int TEST_BIT = 4;
  localparam int PRESCALE_LSB = 16;
  localparam int CARRIER_BIT = 24;
  // Timing config fields.
  localparam int CYCLE_LSB = 24;
  localparam int HIGH_SPAN_LSB = 16;
  localparam int LISTEN_LSB = 8;
  localparam int IDLE_LSB = 0;
  localparam int FIELD_W = 8;
  localparam int WORD_W = 16;
  localparam int COUNT_W = 7;
  // Reset values.
  localparam logic [7:0] CTRL_BITS_RST = 8'h00;
  localparam logic [7:0] FIELD_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // AHB encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [0:0] {
    PH_UPPER = 1'b0,
    PH_LOWER = 1'b1
  } byte_phase_e;
endpackage

// file: rtl/ir_burst_and_carrier_sense.sv
`timescale 1ns/1ps
`default_nettype none
module ir_burst_and_carrier_sense #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Timing strobes.
  input wire logic baudStrobe,
  input wire logic slowTick,
  // Pins.
  input wire logic carrierSenseIn,
  output logic ledDrive,
  output logic receiverPowerCtl,
  // Event pulses.
  output logic holdingEmptyIrq,
  output logic carrierPresentIrq
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : gBadAddrW
    $error("ADDR_W must lie between 8 and 32");
  end

  function automatic logic [7:0] downReload(input logic [7:0] cnt, input logic [7:0] rld);
    downReload = (cnt == 8'h00) ? rld : cnt - 8'h01;
  endfunction

  // Main control readback word; bits runs from the test bit down to the burst enable.
  function automatic logic [31:0] ctlWord(input logic [7:0] prescale, input logic [4:0] bits,
      input logic carrier);
    ctlWord = 32'h0000_0000;
    ctlWord[ir_burst_pkg::CARRIER_BIT] = carrier;
    ctlWord[ir_burst_pkg::PRESCALE_LSB +: ir_burst_pkg::FIELD_W] = prescale;
    ctlWord[ir_burst_pkg::TEST_BIT] = bits[4];
    ctlWord[ir_burst_pkg::POL_FLIP_BIT] = bits[3];
    ctlWord[ir_burst_pkg::RX_PWR_BIT] = bits[2];
    ctlWord[ir_burst_pkg::SENSE_EN_BIT] = bits[1];
    ctlWord[ir_burst_pkg::BURST_EN_BIT] = bits[0];
  endfunction

  // Control state.
  logic burstGenEnable_reg;
  logic carrierSenseEnable_reg;
  logic receiverPower_reg;
  logic outputPolarityFlip_reg;
  logic counterSpeedupTest_reg;
  logic [7:0] prescaleField_reg;
  logic [7:0] cycleField_reg;
  logic [7:0] highSpanField_reg;
  logic [7:0] listenField_reg;
  logic [7:0] idleField_reg;
  logic [15:0] burstWord_reg;

  // Bus data-phase capture.
  logic wrPending_reg;
  logic [11:0] wrAddr_reg;
  logic addrPhase;
  logic [11:0] addrLow;
  logic ctlWriteNow;

  // Synchroniser.
  logic carrierMeta_reg;
  logic carrierSync_reg;

  // Burst generator state.
  logic [7:0] prescaleCnt_reg;
  logic [7:0] periodCnt_reg;
  logic [7:0] onCnt_reg;
  logic [6:0] periodNum_reg;
  logic onOff_reg;
  logic [7:0] parkedByte_reg;
  ir_burst_pkg::byte_phase_e phase_reg;
  logic baudTick;
  logic periodEnd;
  logic loadByte;
  logic [7:0] nextByte;

  // Carrier-sense state.
  logic [7:0] listenCnt_reg;
  logic [7:0] idleCnt_reg;
  logic senseTick;
  logic listenEnd;
  logic sensePower;

  assign hreadyout = 1'b1;
  assign hresp = ir_burst_pkg::HRESP_OKAY;
  assign addrPhase = hsel && hready && (htrans == ir_burst_pkg::HTRANS_NONSEQ);
  assign addrLow = 12'(haddr);
  // A control write landing on the edge that takes a read is forwarded to that read.
  assign ctlWriteNow = wrPending_reg && wrAddr_reg == ir_burst_pkg::MAIN_CONTROL_OFS;

  // Only whole-word writes are meaningful; hsize is accepted as given.
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPending_reg <= 1'b0;
      wrAddr_reg <= 12'h000;
    end else if (ce) begin
      wrPending_reg <= addrPhase && hwrite;
      wrAddr_reg <= addrLow;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      burstGenEnable_reg <= 1'b0;
      carrierSenseEnable_reg <= 1'b0;
      receiverPower_reg <= 1'b0;
      outputPolarityFlip_reg <= 1'b0;
      counterSpeedupTest_reg <= 1'b0;
      prescaleField_reg <= ir_burst_pkg::FIELD_RST;
    end else if (ce && wrPending_reg && wrAddr_reg == ir_burst_pkg::MAIN_CONTROL_OFS) begin
      // (RQ1) Burst enable write.
      burstGenEnable_reg <= hwdata[ir_burst_pkg::BURST_EN_BIT];
      // (RQ7) Sequencer enable write.
      carrierSenseEnable_reg <= hwdata[ir_burst_pkg::SENSE_EN_BIT];
      receiverPower_reg <= hwdata[ir_burst_pkg::RX_PWR_BIT];
      outputPolarityFlip_reg <= hwdata[ir_burst_pkg::POL_FLIP_BIT];
      counterSpeedupTest_reg <= hwdata[ir_burst_pkg::TEST_BIT];
      prescaleField_reg <= hwdata[ir_burst_pkg::PRESCALE_LSB +: ir_burst_pkg::FIELD_W];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cycleField_reg <= ir_burst_pkg::FIELD_RST;
      highSpanField_reg <= ir_burst_pkg::FIELD_RST;
      listenField_reg <= ir_burst_pkg::FIELD_RST;
      idleField_reg <= ir_burst_pkg::FIELD_RST;
    end else if (ce && wrPending_reg && wrAddr_reg == ir_burst_pkg::TIMING_CONFIG_OFS) begin
      cycleField_reg <= hwdata[ir_burst_pkg::CYCLE_LSB +: ir_burst_pkg::FIELD_W];
      highSpanField_reg <= hwdata[ir_burst_pkg::HIGH_SPAN_LSB +: ir_burst_pkg::FIELD_W];
      listenField_reg <= hwdata[ir_burst_pkg::LISTEN_LSB +: ir_burst_pkg::FIELD_W];
      idleField_reg <= hwdata[ir_burst_pkg::IDLE_LSB +: ir_burst_pkg::FIELD_W];
    end
  end

  // A word that is not refilled in time is simply sent again.
  always_ff @(posedge clk) begin
    if (srst) begin
      burstWord_reg <= ir_burst_pkg::WORD_RST;
    end else if (ce && wrPending_reg && wrAddr_reg == ir_burst_pkg::BURST_HOLDING_OFS) begin
      burstWord_reg <= hwdata[ir_burst_pkg::WORD_W-1:0];
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addrPhase && !hwrite) begin
      if (addrLow == ir_burst_pkg::MAIN_CONTROL_OFS) begin
        // (RQ2) Carrier level readback.
        if (ctlWriteNow) begin
          hrdata <= ctlWord(hwdata[ir_burst_pkg::PRESCALE_LSB +: ir_burst_pkg::FIELD_W],
              {hwdata[ir_burst_pkg::TEST_BIT], hwdata[ir_burst_pkg::POL_FLIP_BIT],
              hwdata[ir_burst_pkg::RX_PWR_BIT], hwdata[ir_burst_pkg::SENSE_EN_BIT],
              hwdata[ir_burst_pkg::BURST_EN_BIT]}, carrierSync_reg);
        end else begin
          hrdata <= ctlWord(prescaleField_reg,
              {counterSpeedupTest_reg, outputPolarityFlip_reg, receiverPower_reg,
              carrierSenseEnable_reg, burstGenEnable_reg}, carrierSync_reg);
        end
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // (RQ19) Two-stage synchroniser.
  always_ff @(posedge clk) begin
    if (srst) begin
      carrierMeta_reg <= 1'b0;
      carrierSync_reg <= 1'b0;
    end else if (ce) begin
      carrierMeta_reg <= carrierSenseIn;
      carrierSync_reg <= carrierMeta_reg;
    end
  end

  // (RQ3) Prescaler terminal count.
  assign baudTick = burstGenEnable_reg && prescaleCnt_reg == 8'h00
                    && (baudStrobe || counterSpeedupTest_reg);
  // (RQ8) Period boundary.
  assign periodEnd = baudTick && periodCnt_reg == 8'h00;
  assign loadByte = periodEnd && periodNum_reg == 7'h00;
  // (RQ15) Upper byte first, then the parked lower byte.
  assign nextByte = (phase_reg == ir_burst_pkg::PH_UPPER) ? burstWord_reg[15:8] : parkedByte_reg;

  // (RQ4) Test mode advances the prescaler every clock.
  always_ff @(posedge clk) begin
    if (srst) begin
      prescaleCnt_reg <= 8'h00;
    end else if (ce) begin
      // (RQ20) Counters held in reset.
      if (!burstGenEnable_reg) begin
        prescaleCnt_reg <= 8'h00;
      end else if (baudStrobe || counterSpeedupTest_reg) begin
        // (RQ3) Reload from prescale field.
        prescaleCnt_reg <= downReload(prescaleCnt_reg, prescaleField_reg);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      periodCnt_reg <= 8'h00;
      onCnt_reg <= 8'h00;
    end else if (ce) begin
      if (!burstGenEnable_reg) begin
        periodCnt_reg <= 8'h00;
        onCnt_reg <= 8'h00;
      end else if (baudTick) begin
        // (RQ8) Period counter.
        periodCnt_reg <= downReload(periodCnt_reg, cycleField_reg);
        if (periodEnd) begin
          // (RQ9) On-time load.
          onCnt_reg <= highSpanField_reg;
        end else if (onCnt_reg != 8'h00) begin
          // (RQ18) Freeze at zero.
          onCnt_reg <= onCnt_reg - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      periodNum_reg <= 7'h00;
      onOff_reg <= 1'b0;
      parkedByte_reg <= 8'h00;
      phase_reg <= ir_burst_pkg::PH_UPPER;
    end else if (ce) begin
      if (!burstGenEnable_reg) begin
        periodNum_reg <= 7'h00;
        onOff_reg <= 1'b0;
        phase_reg <= ir_burst_pkg::PH_UPPER;
      end else if (loadByte) begin
        // (RQ12) Seven-bit count from the byte.
        periodNum_reg <= nextByte[6:0];
        // (RQ13) Top bit selects pulses or space.
        onOff_reg <= nextByte[7];
        case (phase_reg)
          ir_burst_pkg::PH_UPPER: begin
            // (RQ16) Park the lower byte.
            parkedByte_reg <= burstWord_reg[7:0];
            phase_reg <= ir_burst_pkg::PH_LOWER;
          end
          ir_burst_pkg::PH_LOWER: begin
            phase_reg <= ir_burst_pkg::PH_UPPER;
          end
          default: begin
            phase_reg <= ir_burst_pkg::PH_UPPER;
          end
        endcase
      end else if (periodEnd) begin
        periodNum_reg <= periodNum_reg - 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      holdingEmptyIrq <= 1'b0;
    end else if (ce) begin
      // (RQ16) Holding-empty pulse.
      holdingEmptyIrq <= loadByte && phase_reg == ir_burst_pkg::PH_UPPER;
    end else begin
      holdingEmptyIrq <= 1'b0;
    end
  end

  // The LED level is registered so the pin never glitches on counter edges.
  always_ff @(posedge clk) begin
    if (srst) begin
      ledDrive <= 1'b0;
    end else if (ce) begin
      // (RQ5) Polarity select; (RQ20) inactive while disabled.
      ledDrive <= outputPolarityFlip_reg
                  ^ (burstGenEnable_reg && onOff_reg && onCnt_reg != 8'h00);
    end
  end

  // (RQ4) Test mode runs the sequencer from the baud strobe.
  assign senseTick = carrierSenseEnable_reg
                     && (counterSpeedupTest_reg ? baudStrobe : slowTick);
  // (RQ10) Listen terminal count.
  assign listenEnd = senseTick && listenCnt_reg == 8'h00;
  assign sensePower = carrierSenseEnable_reg && idleCnt_reg == 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      listenCnt_reg <= 8'h00;
      idleCnt_reg <= 8'h00;
    end else if (ce) begin
      // (RQ7) Idle while disabled.
      if (!carrierSenseEnable_reg) begin
        listenCnt_reg <= 8'h00;
        idleCnt_reg <= 8'h00;
      end else if (senseTick) begin
        // (RQ10) Listen counter.
        listenCnt_reg <= downReload(listenCnt_reg, listenField_reg);
        if (listenEnd) begin
          // (RQ11) Idle counter steps.
          idleCnt_reg <= downReload(idleCnt_reg, idleField_reg);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      carrierPresentIrq <= 1'b0;
    end else if (ce) begin
      // (RQ17) Sample as power drops.
      carrierPresentIrq <= listenEnd && sensePower && idleField_reg != 8'h00
                           && carrierSync_reg;
    end else begin
      carrierPresentIrq <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      receiverPowerCtl <= 1'b0;
    end else if (ce) begin
      // (RQ6) Control bit drives the pin; sequencer adds its window.
      receiverPowerCtl <= receiverPower_reg || sensePower;
    end
  end
endmodule
`default_nettype wire

// file: verification/ir_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module ir_front_end_model (
  // Receiver front end.
  input wire logic receiverPowerCtl,
  input wire logic carrierOn,
  output logic carrierSenseIn
);
  // The detect line has a board pull-down, so an unpowered receiver reads low.
  assign carrierSenseIn = receiverPowerCtl && carrierOn;
endmodule
`default_nettype wire

// file: verification/ir_burst_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ir_burst_asserts #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Bus.
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Pins and events.
  input wire logic slowTick,
  input wire logic ledDrive,
  input wire logic receiverPowerCtl,
  input wire logic holdingEmptyIrq,
  input wire logic carrierPresentIrq
);
  logic ph;
  logic ww;
  logic seen;
  logic [ADDR_W-1:0] wa;
  logic [31:0] ctl;
  logic [7:0] lis;
  logic [8:0] cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    wa <= haddr;
    ww <= hwrite;
    if (srst) begin
      ph <= 1'b0;
      ctl <= '0;
      lis <= '0;
    end else begin
      ph <= hsel && hready && htrans == ir_burst_pkg::HTRANS_NONSEQ && ce;
      if (ph && ww && wa == ir_burst_pkg::MAIN_CONTROL_OFS) ctl <= hwdata;
      if (ph && ww && wa == ir_burst_pkg::TIMING_CONFIG_OFS) lis <= hwdata[15:8];
    end
  end
  // The first window after enabling may start part-way, so it is not judged.
  always_ff @(posedge clk) begin
    if (srst || !ctl[1]) seen <= 1'b0;
    else if ($fell(receiverPowerCtl)) seen <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (srst || !receiverPowerCtl) cnt <= '0;
    else if (slowTick) cnt <= cnt + 9'd1;
  end
  property p_idle_led;
    !ctl[0] && $stable(ctl) && ctl == $past(ctl, 2) |-> ledDrive == ctl[3];
  endproperty
  a_idle_led: assert property (p_idle_led)
    else $error("LED not at idle level");
  property p_rx_bit;
    ctl[2] && $past(ctl[2]) |-> receiverPowerCtl;
  endproperty
  a_rx_bit: assert property (p_rx_bit)
    else $error("Receiver power not following control bit");
  property p_sense_off;
    ctl[2:1] == 2'b00 && $past(ctl[2:1]) == 2'b00 && $past(ctl[2:1], 2) == 2'b00
      |-> !receiverPowerCtl;
  endproperty
  a_sense_off: assert property (p_sense_off)
    else $error("Receiver powered while sensing is off");
  property p_listen;
    $fell(receiverPowerCtl) && seen && ctl[1] && !ctl[4] && !$past(ctl[2])
      |-> cnt == {1'b0, lis} + 9'd1;
  endproperty
  a_listen: assert property (p_listen)
    else $error("Receiver power window has wrong tick count");
  property p_carrier_irq;
    carrierPresentIrq |-> $past(receiverPowerCtl) && ctl[1] ##1 !carrierPresentIrq;
  endproperty
  a_carrier_irq: assert property (p_carrier_irq)
    else $error("Carrier event outside a power-off sample");
  property p_hold_irq;
    holdingEmptyIrq |-> ctl[0] ##1 !holdingEmptyIrq;
  endproperty
  a_hold_irq: assert property (p_hold_irq)
    else $error("Holding-empty event while burst is off");
  property p_ctl_read;
    ph && !ww && wa == ir_burst_pkg::MAIN_CONTROL_OFS |-> hrdata[23:0] == {ctl[23:16], 11'h0,
      ctl[4:0]} && hrdata[31:25] == 7'h00;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("Control readback mismatch");
  property p_wo_read;
    ph && !ww && (wa == ir_burst_pkg::TIMING_CONFIG_OFS || wa == ir_burst_pkg::BURST_HOLDING_OFS)
      |-> hrdata == 32'h0000_0000;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("Write-only register read nonzero");
endmodule
bind ir_burst_and_carrier_sense ir_burst_asserts #(.ADDR_W(ADDR_W)) chk (
  .clk, .srst, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .slowTick, .ledDrive, .receiverPowerCtl, .holdingEmptyIrq, .carrierPresentIrq
);
`default_nettype wire

// file: verification/test_ir_burst_and_carrier_sense.sv
`timescale 1ns/1ps
`default_nettype none
module test_ir_burst_and_carrier_sense;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic baudStrobe = 1'b0;
  logic slowTick = 1'b0;
  logic carrierOn = 1'b0;
  logic sel = 1'b0;
  logic pl = 1'b0;
  logic hreadyout, hresp, carrierSenseIn, ledDrive, receiverPowerCtl;
  logic holdingEmptyIrq, carrierPresentIrq;
  logic [31:0] hrdata;
  int n_fail = 0;
  int check_count = 0;
  int bc = 0;
  int sc = 0;
  int c, hi, ed;
  wire logic sig = sel ? receiverPowerCtl : ledDrive ^ pl;
  wire logic ev = sel ? carrierPresentIrq : holdingEmptyIrq;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    bc <= (bc + 1) % 4;
    sc <= (sc + 1) % 10;
    baudStrobe <= bc == 3;
    slowTick <= sc == 9;
  end
  ir_burst_and_carrier_sense DUT (
    .clk(clk), .srst(srst), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .baudStrobe(baudStrobe),
    .slowTick(slowTick), .carrierSenseIn(carrierSenseIn), .ledDrive(ledDrive),
    .receiverPowerCtl(receiverPowerCtl), .holdingEmptyIrq(holdingEmptyIrq),
    .carrierPresentIrq(carrierPresentIrq)
  );
  ir_front_end_model far (
    .receiverPowerCtl(receiverPowerCtl), .carrierOn(carrierOn),
    .carrierSenseIn(carrierSenseIn)
  );
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= ir_burst_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk("hrdata", e, hrdata);
    chk("hresp", 32'(ir_burst_pkg::HRESP_OKAY), 32'(hresp));
  endtask
  // Cycles, active cycles and rising edges of sig between two events.
  task automatic meas();
    logic prev;
    c = 0;
    hi = 0;
    ed = 0;
    for (int i = 0; i < 400 && ev !== 1'b1; i++) @(posedge clk);
    prev = sig;
    do begin
      @(posedge clk);
      c++;
      hi += sig;
      ed += (sig && !prev);
      prev = sig;
    end while (c < 400 && ev !== 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(ir_burst_pkg::MAIN_CONTROL_OFS, 32'h0000_0000);
    rd(ir_burst_pkg::TIMING_CONFIG_OFS, 32'h0000_0000);
    rd(ir_burst_pkg::BURST_HOLDING_OFS, 32'h0000_0000);
    rd(12'h0B0, 32'h0000_0000);
    xfer(1'b1, ir_burst_pkg::TIMING_CONFIG_OFS, 32'h0301_0102);
    xfer(1'b1, ir_burst_pkg::BURST_HOLDING_OFS, 32'h0000_8201);
    // Passes 0 and 1 keep the test bit clear; pass 2 is a production-test pass.
    for (int p = 0; p < 3; p++) begin
      pl <= p[0];
      xfer(1'b1, ir_burst_pkg::MAIN_CONTROL_OFS, {16'h0001, 11'h000, p[1], p[0], 3'b001});
      meas();
      chk("wordCycles", p[1] ? 32'd40 : 32'd160, c);
      chk("activeCycles", p[1] ? 32'd6 : 32'd24, hi);
      chk("pulses", 32'd3, ed);
    end
    carrierOn <= 1'b1;
    sel <= 1'b1;
    xfer(1'b1, ir_burst_pkg::MAIN_CONTROL_OFS, 32'h0000_000A);
    meas();
    chk("senseCycles", 32'd60, c);
    chk("powerCycles", 32'd20, hi);
    carrierOn <= 1'b0;
    repeat (4) @(posedge clk);
    meas();
    chk("noCarrier", 32'd400, c);
    xfer(1'b1, ir_burst_pkg::MAIN_CONTROL_OFS, 32'h0000_0004);
    carrierOn <= 1'b1;
    repeat (5) @(posedge clk);
    chk("rxPower", 32'd1, 32'(receiverPowerCtl));
    rd(ir_burst_pkg::MAIN_CONTROL_OFS, 32'h0100_0004);
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
